/* usc_pkg.sv */
// package: register map, field positions, counts and states of the
// serial status-two / control-three block
// assumes byte addresses on the register bus, one word per register
package usc_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [4:0] OFS_STATUS_TWO    = 5'h00;
	localparam logic [4:0] OFS_CONTROL_THREE = 5'h04;
	localparam logic [4:0] OFS_DATA          = 5'h08;
	localparam logic [4:0] OFS_CONTROL       = 5'h0C;
	localparam logic [4:0] OFS_STATUS_ONE    = 5'h10;
	// serial_status_two fields
	localparam int S2_BRK   = 7;
	localparam int S2_EDGE  = 6;
	localparam int S2_RX_INVERT = 4;
	localparam int S2_WIDLE = 3;
	localparam int S2_LBRK  = 2;
	localparam int S2_EBD   = 1;
	localparam int S2_RAF   = 0;
	// serial_control_three fields
	localparam int C3_R9    = 7;
	localparam int C3_T9    = 6;
	localparam int C3_DIR   = 5;
	localparam int C3_TX_INVERT = 4;
	localparam int C3_OVERRUN_IRQ_ENABLE  = 3;
	localparam int C3_NOISE_IRQ_ENABLE  = 2;
	localparam int C3_FRAMING_IRQ_ENABLE  = 1;
	localparam int C3_PARITY_IRQ_ENABLE  = 0;
	// serial_control fields
	localparam int CTL_M9   = 0;
	localparam int CTL_LOOP = 1;
	localparam int CTL_RX_SOURCE_SELECT = 2;
	localparam int CTL_STBY = 3;
	localparam int CTL_SBK  = 4;
	// serial_status_one fields
	localparam int S1_TXRDY = 7;
	localparam int S1_FULL  = 5;
	localparam int S1_IDLE  = 4;
	localparam int S1_OR    = 3;
	localparam int S1_NF    = 2;
	localparam int S1_FE    = 1;
	localparam int S1_PF    = 0;
	// reset values
	localparam logic [7:0] S2_RESET  = 8'h00;
	localparam logic [7:0] C3_RESET  = 8'h00;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// bit-time counts, 8-bit mode; 9-bit mode adds one
	localparam logic [3:0] BRK_DET_BASE = 4'hA;
	localparam logic [3:0] BRK_DET_EXT  = 4'hB;
	localparam logic [3:0] TX_BRK_BASE  = 4'hA;
	localparam logic [3:0] TX_BRK_LONG  = 4'hD;
	localparam logic [3:0] FRAME_BASE   = 4'hA;
	localparam logic [3:0] DATA_BITS    = 4'h8;
	localparam logic [3:0] CNT_MAX      = 4'hF;
	// transmit buffer
	localparam int TXW_W    = 9;
	localparam int TX_DEPTH = 8;
	typedef enum {RX_IDLE, RX_FRAME} usc_rx_state_t;
	typedef enum {TX_IDLE, TX_SHIFT, TX_BREAK} usc_tx_state_t;
endpackage

/* usc_fifo.sv */
// first-in first-out buffer with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module usc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	// pointer and count update; full and empty straight from the count
	always_comb begin
		push       = in_valid && in_ready;
		pop        = out_valid && out_ready;
		wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
		rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
		cnt_nxt    = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	assign in_ready  = (cnt_r != FULL_CNT);
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rd_ptr_r];

	// storage is not reset; only the pointers and the count need a defined state
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r    <= cnt_nxt;
		end
	end
endmodule

/* usc_top.sv */
// serial line status-two / control-three logic with a small framer
// assumes bit_tick pulses once per bit time, centred in the bit, from an
// outside rate generator; pins are synchronous to mclk
//
// Function
// - break recognised sets break flag; one clears
// - active rx edge sets edge flag; one clears
// - rx inversion applies to whole received frame
// - standby idle sets idle flag only if enabled
// - tx break 10 or 13 bits, plus nine-bit
// - long break setting leaves framing check alone
// - break threshold 10 or 11 bits, plus nine-bit
// - extended break blocks framing and full flags
// - active flag set on start, cleared on idle
// - ninth received bit shown in control-three bit 7
// - ninth tx bit captured with data write
// - single-wire direction bit steers tx pin
// - tx inversion applies to whole sent frame
// - overrun and noise flags request interrupt
// - framing and parity flags request interrupt
// - data length bit selects 8/9 data bits
`timescale 1ns/1ps
module usc_top (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic [usc_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [usc_pkg::DATA_W-1:0]  avs_writedata,
	output logic      [usc_pkg::DATA_W-1:0]  avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic                        bit_tick,
	input  wire logic                        rxd_i,
	input  wire logic                        txd_i,
	output logic                             txd_o,
	output logic                             txd_oe,
	input  wire logic                        noise_flag_i,
	input  wire logic                        parity_error_flag_i,
	output logic                             err_irq
);
	import usc_pkg::*;

	// bus side
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic        resp_r, resp_nxt, wait_r, wait_nxt;
	logic        wr_acc, rd_acc, wr_s2, wr_c3, wr_ctl, wr_dat, rd_dat;
	// register state
	logic [7:0]  s2_r, s2_nxt, c3_r, c3_nxt, ctl_r, ctl_nxt;
	logic [7:0]  rx_data_r, rx_data_nxt;
	logic        full_r, full_nxt, idle_r, idle_nxt;
	logic        ovr_r, ovr_nxt, fe_r, fe_nxt;
	// receiver
	usc_rx_state_t rx_st_r, rx_st_nxt;
	logic [8:0]  rx_sh_r, rx_sh_nxt;
	logic [3:0]  rx_cnt_r, rx_cnt_nxt, low_r, low_nxt;
	logic [3:0]  hi_r, hi_nxt, brk_thr, frame_len, nbits;
	logic        rx_prev_r, arm_r, arm_nxt;
	logic        rx_src, rx_in, edge_evt, brk_evt, idle_evt;
	logic        start_evt, char_evt, stop_bad, m9, single_wire;
	// transmitter
	usc_tx_state_t tx_st_r, tx_st_nxt;
	logic [9:0]  tx_sh_r, tx_sh_nxt;
	logic [3:0]  tx_cnt_r, tx_cnt_nxt, tx_brk_len;
	logic        tx_line_r, tx_line_nxt;
	logic        txd_r, txd_oe_r, irq_r;
	logic        fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [TXW_W-1:0] fifo_out;

	assign m9          = ctl_r[CTL_M9];
	assign single_wire = ctl_r[CTL_LOOP] && ctl_r[CTL_RX_SOURCE_SELECT];
	assign nbits       = DATA_BITS + {3'h0, m9};
	assign frame_len   = FRAME_BASE + {3'h0, m9};
	assign brk_thr     = (s2_r[S2_EBD] ? BRK_DET_EXT : BRK_DET_BASE)
		+ {3'h0, m9};
	assign tx_brk_len  = (s2_r[S2_LBRK] ? TX_BRK_LONG : TX_BRK_BASE)
		+ {3'h0, m9};

	// bus handshake: one wait cycle, a full buffer stalls data writes
	always_comb begin
		resp_nxt = (avs_read || avs_write) && !resp_r
			&& !(avs_write && avs_address == OFS_DATA && !fifo_in_ready);
		wait_nxt = !resp_nxt;
		wr_acc   = resp_r && avs_write;
		rd_acc   = resp_r && avs_read;
		wr_s2    = wr_acc && avs_address == OFS_STATUS_TWO;
		wr_c3    = wr_acc && avs_address == OFS_CONTROL_THREE;
		wr_ctl   = wr_acc && avs_address == OFS_CONTROL;
		wr_dat   = wr_acc && avs_address == OFS_DATA;
		rd_dat   = rd_acc && avs_address == OFS_DATA;
		rdata_nxt = rdata_r;
		if (resp_nxt && avs_read) begin
			rdata_nxt = '0; // unmapped reads answer zero
			unique case (avs_address)
				OFS_STATUS_TWO:    rdata_nxt[7:0] = s2_r;
				OFS_CONTROL_THREE: rdata_nxt[7:0] = c3_r;
				OFS_CONTROL:       rdata_nxt[7:0] = ctl_r;
				OFS_DATA:          rdata_nxt[7:0] = rx_data_r;
				OFS_STATUS_ONE: begin
					rdata_nxt[S1_TXRDY] = fifo_in_ready;
					rdata_nxt[S1_FULL]  = full_r;
					rdata_nxt[S1_IDLE]  = idle_r;
					rdata_nxt[S1_OR]    = ovr_r;
					rdata_nxt[S1_NF]    = noise_flag_i;
					rdata_nxt[S1_FE]    = fe_r;
					rdata_nxt[S1_PF]    = parity_error_flag_i;
				end
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			resp_r  <= 1'b0;
			wait_r  <= 1'b1;
			rdata_r <= '0;
		end else begin
			resp_r  <= resp_nxt;
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// receive source: pin, internal loop or shared tx pin
	always_comb begin
		if (ctl_r[CTL_LOOP]) begin
			rx_src = ctl_r[CTL_RX_SOURCE_SELECT] ? txd_i : tx_line_r;
		end else begin
			rx_src = rxd_i;
		end
		rx_in    = rx_src ^ s2_r[S2_RX_INVERT];
		edge_evt = rx_prev_r && !rx_in;
	end

	// receiver framing, low-run and high-run counters
	always_comb begin
		rx_st_nxt  = rx_st_r;
		rx_sh_nxt  = rx_sh_r;
		rx_cnt_nxt = rx_cnt_r;
		low_nxt    = low_r;
		hi_nxt     = hi_r;
		arm_nxt    = arm_r;
		start_evt  = 1'b0;
		char_evt   = 1'b0;
		stop_bad   = 1'b0;
		brk_evt    = bit_tick && !rx_in && (low_r == brk_thr - 4'h1);
		idle_evt   = bit_tick && rx_in && arm_r
			&& (hi_r == frame_len - 4'h1);
		if (bit_tick) begin
			low_nxt = rx_in ? 4'h0 : (low_r == CNT_MAX ? low_r : low_r + 4'h1);
			hi_nxt  = !rx_in ? 4'h0 : (hi_r == CNT_MAX ? hi_r : hi_r + 4'h1);
			if (!rx_in) begin
				arm_nxt = 1'b1;
			end else if (idle_evt) begin
				arm_nxt = 1'b0;
			end
			unique case (rx_st_r)
				RX_IDLE: if (!rx_in) begin
					start_evt  = 1'b1;
					rx_st_nxt  = RX_FRAME;
					rx_cnt_nxt = 4'h0;
				end
				RX_FRAME: if (rx_cnt_r != nbits) begin
					rx_sh_nxt  = {rx_in, rx_sh_r[8:1]};
					rx_cnt_nxt = rx_cnt_r + 4'h1;
				end else begin
					char_evt  = 1'b1;
					stop_bad  = !rx_in;
					rx_st_nxt = RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rx_st_r   <= RX_IDLE;
			rx_sh_r   <= '0;
			rx_cnt_r  <= '0;
			low_r     <= '0;
			hi_r      <= '0;
			arm_r     <= 1'b0;
			rx_prev_r <= 1'b1;
		end else begin
			rx_st_r   <= rx_st_nxt;
			rx_sh_r   <= rx_sh_nxt;
			rx_cnt_r  <= rx_cnt_nxt;
			low_r     <= low_nxt;
			hi_r      <= hi_nxt;
			arm_r     <= arm_nxt;
			rx_prev_r <= rx_in;
		end
	end

	// registers and flags; a hardware set wins over any clear
	always_comb begin
		s2_nxt      = s2_r;
		c3_nxt      = c3_r;
		ctl_nxt     = ctl_r;
		rx_data_nxt = rx_data_r;
		full_nxt    = full_r;
		idle_nxt    = idle_r;
		ovr_nxt     = ovr_r;
		fe_nxt      = fe_r;
		if (wr_s2) begin
			s2_nxt[S2_RX_INVERT:S2_EBD] = avs_writedata[S2_RX_INVERT:S2_EBD];
			s2_nxt[S2_BRK]  = s2_r[S2_BRK] && !avs_writedata[S2_BRK];
			s2_nxt[S2_EDGE] = s2_r[S2_EDGE] && !avs_writedata[S2_EDGE];
		end
		if (wr_c3) begin
			c3_nxt[C3_T9:C3_PARITY_IRQ_ENABLE] = avs_writedata[C3_T9:C3_PARITY_IRQ_ENABLE];
		end
		if (wr_ctl) begin
			ctl_nxt[CTL_SBK:CTL_M9] = avs_writedata[CTL_SBK:CTL_M9];
		end
		if (rd_dat) begin
			// one-step clear: reading the data word retires the char
			full_nxt = 1'b0;
			idle_nxt = 1'b0;
			ovr_nxt  = 1'b0;
			fe_nxt   = 1'b0;
		end
		if (brk_evt) begin
			s2_nxt[S2_BRK] = 1'b1;
		end
		if (edge_evt) begin
			s2_nxt[S2_EDGE] = 1'b1;
		end
		if (start_evt) begin
			s2_nxt[S2_RAF] = 1'b1;
		end else if (idle_evt) begin
			s2_nxt[S2_RAF] = 1'b0;
		end
		if (idle_evt && (!ctl_r[CTL_STBY] || s2_r[S2_WIDLE])) begin
			idle_nxt = 1'b1;
		end
		// no delivery while extended break detect is on
		if (char_evt && !s2_r[S2_EBD] && !ctl_r[CTL_STBY]) begin
			if (full_r && !rd_dat) begin
				ovr_nxt = 1'b1; // new char lost
			end else begin
				full_nxt       = 1'b1;
				fe_nxt         = stop_bad;
				rx_data_nxt    = m9 ? rx_sh_r[7:0] : rx_sh_r[8:1];
				c3_nxt[C3_R9]  = m9 && rx_sh_r[8];
			end
		end
		s2_nxt[S2_EDGE-1] = 1'b0; // unused bit reads zero
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s2_r      <= S2_RESET;
			c3_r      <= C3_RESET;
			ctl_r     <= CTL_RESET;
			rx_data_r <= '0;
			full_r    <= 1'b0;
			idle_r    <= 1'b0;
			ovr_r     <= 1'b0;
			fe_r      <= 1'b0;
		end else begin
			s2_r      <= s2_nxt;
			c3_r      <= c3_nxt;
			ctl_r     <= ctl_nxt;
			rx_data_r <= rx_data_nxt;
			full_r    <= full_nxt;
			idle_r    <= idle_nxt;
			ovr_r     <= ovr_nxt;
			fe_r      <= fe_nxt;
		end
	end

	// tx words carry the ninth bit as it stood at the data write
	usc_fifo #(
		.WIDTH (TXW_W),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (wr_dat),
		.in_ready  (fifo_in_ready),
		.in_data   ({c3_r[C3_T9], avs_writedata[7:0]}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out)
	);

	// transmitter: a queued break goes ahead of buffered data
	always_comb begin
		tx_st_nxt   = tx_st_r;
		tx_sh_nxt   = tx_sh_r;
		tx_cnt_nxt  = tx_cnt_r;
		tx_line_nxt = tx_line_r;
		fifo_pop    = 1'b0;
		if (bit_tick) begin
			unique case (tx_st_r)
				TX_IDLE: if (ctl_r[CTL_SBK]) begin
					tx_st_nxt   = TX_BREAK;
					tx_cnt_nxt  = tx_brk_len - 4'h1;
					tx_line_nxt = 1'b0;
				end else if (fifo_out_valid) begin
					fifo_pop    = 1'b1;
					tx_st_nxt   = TX_SHIFT;
					tx_sh_nxt   = m9 ? {1'b1, fifo_out}
						: {2'b11, fifo_out[7:0]};
					tx_cnt_nxt  = frame_len - 4'h1;
					tx_line_nxt = 1'b0;
				end
				TX_SHIFT: if (tx_cnt_r == 4'h0) begin
					tx_st_nxt   = TX_IDLE;
					tx_line_nxt = 1'b1;
				end else begin
					tx_line_nxt = tx_sh_r[0];
					tx_sh_nxt   = {1'b1, tx_sh_r[9:1]};
					tx_cnt_nxt  = tx_cnt_r - 4'h1;
				end
				TX_BREAK: if (tx_cnt_r == 4'h0) begin
					tx_st_nxt   = TX_IDLE;
					tx_line_nxt = 1'b1;
				end else begin
					tx_cnt_nxt  = tx_cnt_r - 4'h1;
				end
			endcase
		end
	end

	// pin drive and error request, registered for clean outputs
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_st_r   <= TX_IDLE;
			tx_sh_r   <= '0;
			tx_cnt_r  <= '0;
			tx_line_r <= 1'b1;
			txd_r     <= 1'b1;
			txd_oe_r  <= 1'b1;
			irq_r     <= 1'b0;
		end else begin
			tx_st_r   <= tx_st_nxt;
			tx_sh_r   <= tx_sh_nxt;
			tx_cnt_r  <= tx_cnt_nxt;
			tx_line_r <= tx_line_nxt;
			txd_r     <= tx_line_r ^ c3_r[C3_TX_INVERT];
			txd_oe_r  <= !single_wire || c3_r[C3_DIR];
			irq_r     <= (ovr_r && c3_r[C3_OVERRUN_IRQ_ENABLE])
				|| (noise_flag_i && c3_r[C3_NOISE_IRQ_ENABLE])
				|| (fe_r && c3_r[C3_FRAMING_IRQ_ENABLE])
				|| (parity_error_flag_i && c3_r[C3_PARITY_IRQ_ENABLE]);
		end
	end

	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
	assign txd_o           = txd_r;
	assign txd_oe          = txd_oe_r;
	assign err_irq         = irq_r;

	// helper: bit times spent in the break state
	logic [3:0] brk_ticks_r;
	always_ff @(posedge mclk) begin
		if (!rst_n || tx_st_r != TX_BREAK) begin
			brk_ticks_r <= '0;
		end else if (bit_tick) begin
			brk_ticks_r <= brk_ticks_r + 4'h1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_w1c_zero;
		wr_s2 && !avs_writedata[S2_BRK] && s2_r[S2_BRK];
	endsequence

	AST_BRK_SET: assert property (brk_evt |=> s2_r[S2_BRK])
		else $error("break flag not set");
	AST_W1C_KEEP: assert property (s_w1c_zero |=> s2_r[S2_BRK])
		else $error("zero write cleared break flag");
	AST_EDGE_INV: assert property (bit_tick ##0 1 ##1
		(s2_r[S2_RX_INVERT] && $stable(s2_r[S2_RX_INVERT]) && $rose(rx_src)
		&& !ctl_r[CTL_LOOP]) |=> s2_r[S2_EDGE])
		else $error("inverted rising edge missed");
	AST_EDGE_SET: assert property (edge_evt |=> s2_r[S2_EDGE])
		else $error("edge flag not set");
	AST_IDLE_STBY: assert property ((idle_evt && ctl_r[CTL_STBY]
		&& !s2_r[S2_WIDLE] && !idle_r) |=> !idle_r)
		else $error("idle set in standby");
	AST_BRK_LEN: assert property ((tx_st_r == TX_BREAK && bit_tick
		&& tx_cnt_r == 4'h0 && $stable(ctl_r) && $stable(s2_r[S2_LBRK]))
		|-> brk_ticks_r + 4'h1 == tx_brk_len)
		else $error("tx break length wrong");
	AST_EBD_BLOCK: assert property (s2_r[S2_EBD] && !full_r
		|=> !full_r)
		else $error("full flag set under extended break");
	AST_RAF: assert property (start_evt |=> s2_r[S2_RAF]
		##[0:300] 1)
		else $error("active flag not set");
	AST_RAF_CLR: assert property (idle_evt |=> !s2_r[S2_RAF])
		else $error("active flag not cleared on idle");
	AST_TX_INV: assert property ((tx_st_r == TX_IDLE && tx_line_r
		&& !wr_c3 && $stable(c3_r[C3_TX_INVERT]))
		|=> txd_o == !c3_r[C3_TX_INVERT])
		else $error("idle tx level wrong");
	AST_DIR: assert property ((single_wire && $stable(ctl_r)
		&& $stable(c3_r) && !wr_c3) |=> txd_oe == c3_r[C3_DIR])
		else $error("single-wire direction wrong");
	AST_IRQ: assert property ((ovr_r && c3_r[C3_OVERRUN_IRQ_ENABLE])
		|=> err_irq)
		else $error("overrun request missing");
	AST_IRQ_FE: assert property ((fe_r && c3_r[C3_FRAMING_IRQ_ENABLE])
		|=> err_irq)
		else $error("framing request missing");
endmodule

/* usc_remote.sv */
// remote serial node: drives the receive line, samples the transmit pin
// assumes bit_tick pulses once per bit time and comes from the bench
`timescale 1ns/1ps
module usc_remote (
	input  wire logic mclk,
	input  wire logic bit_tick,
	input  wire logic line_in,
	output logic      line_out
);
	logic inv = 1'b0;
	logic v;
	initial line_out = 1'b1;
	// wait for the next bit boundary
	task automatic tk();
		do @(posedge mclk); while (bit_tick !== 1'b1);
	endtask
	// sender polarity; the idle level follows it
	task automatic set_inv(input logic i);
		inv = i;
		line_out <= ~i;
	endtask
	// one frame lsb first; stop may be forced low for a framing fault
	task automatic send(input logic [8:0] d, input int nb, input logic stp);
		tk();
		line_out <= inv;
		for (int i = 0; i < nb; i++) begin
			tk();
			line_out <= d[i] ^ inv;
		end
		tk();
		line_out <= stp ^ inv;
		tk();
		line_out <= ~inv;
		tk(); // margin so the receiver finishes delivery
	endtask
	// low run of n bit times, then back to mark
	task automatic low(input int n);
		tk();
		line_out <= inv;
		repeat (n) tk();
		line_out <= ~inv;
	endtask
	// sample early in the bit, two clocks after the tick, clear of the pin lag
	task automatic smp(input logic ti);
		tk();
		repeat (2) @(posedge mclk);
		v = line_in ^ ti;
	endtask
	// bounded hunt for a start bit
	task automatic hunt(input logic ti, output logic ok);
		ok = 1'b0;
		for (int w = 0; w < 600 && !ok; w++) begin
			smp(ti);
			ok = (v === 1'b0);
		end
	endtask
	task automatic catch(input int nb, input logic ti,
			output logic [8:0] d, output logic ok);
		d = '0;
		hunt(ti, ok);
		for (int i = 0; i < nb; i++) begin
			smp(ti);
			d[i] = v;
		end
	endtask
	// count low bit times of one break, capped
	task automatic lows(output int n, output logic ok);
		hunt(1'b0, ok);
		n = 0;
		while (v === 1'b0 && n < 40) begin
			n++;
			smp(1'b0);
		end
	endtask
endmodule

/* usc_top_tb.sv */
// bench for the status-two / control-three block
// assumes usc_pkg and usc_remote are compiled first
`timescale 1ns/1ps
module usc_top_tb;
	import usc_pkg::*;
	logic              mclk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic              bit_tick, rxd, txd_i, txd_o, txd_oe, err_irq, ok;
	logic              noise_flag_i, parity_error_flag_i;
	logic [ADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata;
	logic [2:0]        tick_cnt;
	logic [31:0]       seed, rd_v;
	logic [8:0]        b, got;
	logic [7:0]        txq [0:8];
	int                n_mismatch, n_checks, n, k;
	// shared pin with pull-up while nobody drives
	assign txd_i = txd_oe ? txd_o : 1'b1;
	usc_top i_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .bit_tick(bit_tick),
		.rxd_i(rxd), .txd_i(txd_i), .txd_o(txd_o), .txd_oe(txd_oe),
		.noise_flag_i(noise_flag_i),
		.parity_error_flag_i(parity_error_flag_i), .err_irq(err_irq));
	usc_remote i_remote (.mclk(mclk), .bit_tick(bit_tick),
		.line_in(txd_o), .line_out(rxd));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// bit tick every eight clocks keeps runs short
	always @(posedge mclk) begin
		tick_cnt <= tick_cnt + 3'h1;
		bit_tick <= (tick_cnt == 3'h7);
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected counts in bit times
	function automatic int brk_len(input logic lng, input logic nine);
		return (lng ? 13 : 10) + nine;
	endfunction
	function automatic int brk_th(input logic ext, input logic nine);
		return (ext ? 11 : 10) + nine;
	endfunction
	task automatic print_verdict();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		n_checks++;
		if (got_v !== exp_v) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask
	// a bounded wait that ran out ends the run as a failure
	task automatic tmo(input logic done);
		if (done !== 1'b1) begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic rw, input logic [4:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		int i;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= ~rw;
		avs_write <= rw;
		for (i = 0; i < 3000; i++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 3000) begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd_v);
	endtask
	task automatic rc(input logic [4:0] a, input logic [31:0] m,
			input logic [31:0] e);
		bus(1'b0, a, 32'h0, rd_v);
		chk(rd_v & m, e);
	endtask
	task automatic ticks(input int t);
		repeat (t * 8) @(posedge mclk);
	endtask
	// main sequence
	initial begin
		seed = 32'h2A;
		n_mismatch = 0;
		n_checks = 0;
		tick_cnt = 3'h0;
		bit_tick = 1'b0;
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		noise_flag_i = 1'b0;
		parity_error_flag_i = 1'b0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		rc(OFS_STATUS_TWO, 32'hFFFFFFFF, {24'h0, S2_RESET});
		rc(OFS_CONTROL_THREE, 32'hFFFFFFFF, {24'h0, C3_RESET});
		wr(OFS_CONTROL_THREE, 32'hFF);
		rc(OFS_CONTROL_THREE, 32'hFF, 32'h7F);
		chk({31'h0, txd_o}, 32'h0);
		wr(OFS_STATUS_TWO, 32'h0E);
		rc(OFS_STATUS_TWO, 32'hFF, 32'h0E);
		wr(5'h14, 32'hFF);
		rc(5'h14, 32'hFFFFFFFF, 32'h0);
		wr(OFS_CONTROL_THREE, 32'h0);
		wr(OFS_STATUS_TWO, 32'h0);
		// receive in both lengths; active flag looked at mid-frame
		for (k = 0; k < 4; k++) begin
			b = 9'(rnd());
			b[8] = b[8] & k[0];
			wr(OFS_CONTROL, {31'h0, k[0]});
			fork
				i_remote.send(b, 8 + k[0], 1'b1);
				begin
					ticks(4);
					rc(OFS_STATUS_TWO, 32'h1, 32'h1);
				end
			join
			rc(OFS_CONTROL_THREE, 32'h80, {24'h0, b[8], 7'h0});
			rc(OFS_DATA, 32'hFF, {24'h0, b[7:0]});
			ticks(13);
			rc(OFS_STATUS_TWO, 32'h41, 32'h40);
			wr(OFS_STATUS_TWO, 32'h0);
			rc(OFS_STATUS_TWO, 32'h40, 32'h40);
			wr(OFS_STATUS_TWO, 32'h40);
			rc(OFS_STATUS_TWO, 32'h40, 32'h0);
		end
		// break detect: one short of the threshold, then the threshold
		for (k = 0; k < 4; k++) begin
			wr(OFS_CONTROL, {31'h0, k[0]});
			wr(OFS_STATUS_TWO, {24'h0, 2'h3, 4'h0, k[1], 1'b0});
			i_remote.low(brk_th(k[1], k[0]) - 1);
			ticks(2);
			rc(OFS_STATUS_TWO, 32'h80, 32'h0);
			bus(1'b0, OFS_DATA, 32'h0, rd_v);
			ticks(13);
			i_remote.low(brk_th(k[1], k[0]));
			ticks(2);
			rc(OFS_STATUS_TWO, 32'h80, 32'h80);
			wr(OFS_STATUS_TWO, {30'h0, k[1], 1'b0});
			rc(OFS_STATUS_TWO, 32'h80, 32'h80);
			if (k[1])
				rc(OFS_STATUS_ONE, 32'h22, 32'h0);
			bus(1'b0, OFS_DATA, 32'h0, rd_v);
			ticks(13);
		end
		// all four error flags up, then each enable alone
		wr(OFS_STATUS_TWO, 32'hC4);
		wr(OFS_CONTROL, 32'h0);
		noise_flag_i <= 1'b1;
		parity_error_flag_i <= 1'b1;
		i_remote.send(9'h0A5, 8, 1'b0);
		i_remote.send(9'h05A, 8, 1'b1);
		rc(OFS_STATUS_ONE, 32'h2F, 32'h2F);
		for (k = 0; k < 4; k++) begin
			wr(OFS_CONTROL_THREE, 32'h1 << k);
			repeat (3) @(posedge mclk);
			chk({31'h0, err_irq}, 32'h1);
		end
		wr(OFS_CONTROL_THREE, 32'h0);
		repeat (3) @(posedge mclk);
		chk({31'h0, err_irq}, 32'h0);
		noise_flag_i <= 1'b0;
		parity_error_flag_i <= 1'b0;
		ticks(13);
		// standby: idle flag only with wake idle detect
		wr(OFS_CONTROL, 32'h08);
		for (k = 0; k < 2; k++) begin
			wr(OFS_STATUS_TWO, {28'h0, k[0], 3'h0});
			bus(1'b0, OFS_DATA, 32'h0, rd_v);
			i_remote.send(9'(rnd() & 32'hFF), 8, 1'b1);
			ticks(13);
			rc(OFS_STATUS_ONE, 32'h10, {27'h0, k[0], 4'h0});
		end
		wr(OFS_CONTROL, 32'h0);
		// fill the buffer past its depth while the remote listens
		fork
			for (n = 0; n < TX_DEPTH + 1; n++) begin
				i_remote.catch(8, 1'b0, got, ok);
				tmo(ok);
				chk({23'h0, got}, {24'h0, txq[n]});
			end
			begin
				for (k = 0; k < TX_DEPTH + 1; k++) begin
					txq[k] = 8'(rnd());
					wr(OFS_DATA, {24'h0, txq[k]});
				end
				rc(OFS_STATUS_ONE, 32'h80, 32'h0);
			end
		join
		rc(OFS_STATUS_ONE, 32'h80, 32'h80);
		// nine-bit, then inverted transmit
		for (k = 1; k < 3; k++) begin
			wr(OFS_CONTROL, {31'h0, k == 1});
			wr(OFS_CONTROL_THREE, (k == 1) ? 32'h40 : 32'h10);
			b = {k == 1, 8'(rnd())};
			fork
				i_remote.catch(8 + (k == 1), k == 2, got, ok);
				wr(OFS_DATA, {24'h0, b[7:0]});
			join
			tmo(ok);
			chk({23'h0, got}, {23'h0, b});
		end
		wr(OFS_CONTROL_THREE, 32'h0);
		// transmit break length, both settings and both word lengths
		for (k = 0; k < 4; k++) begin
			wr(OFS_STATUS_TWO, {29'h0, k[1], 2'h0});
			fork
				i_remote.lows(n, ok);
				begin
					wr(OFS_CONTROL, {27'h0, 1'b1, 3'h0, k[0]});
					for (int w = 0; w < 200 && txd_o !== 1'b0; w++)
						@(posedge mclk);
					tmo(txd_o === 1'b0);
					wr(OFS_CONTROL, {31'h0, k[0]});
				end
			join
			tmo(ok);
			chk(32'(n), 32'(brk_len(k[1], k[0])));
			ticks(4);
		end
		// single wire: direction bit steers the pin driver
		wr(OFS_CONTROL, 32'h06);
		for (k = 0; k < 2; k++) begin
			wr(OFS_CONTROL_THREE, {26'h0, k[0], 5'h0});
			repeat (2) @(posedge mclk);
			chk({31'h0, txd_oe}, {31'h0, k[0]});
		end
		wr(OFS_CONTROL, 32'h0);
		// inverted receive; the switch-over glitch is flushed first
		i_remote.set_inv(1'b1);
		wr(OFS_STATUS_TWO, 32'h10);
		ticks(13);
		bus(1'b0, OFS_DATA, 32'h0, rd_v);
		b = 9'(rnd() & 32'hFF);
		i_remote.send(b, 8, 1'b1);
		rc(OFS_DATA, 32'hFF, {23'h0, b});
		print_verdict();
	end
endmodule
